// File: timer16_register_access.sv
// Purpose: 16-bit timer core with byte-wide register access over Avalon-MM.
// Assumes: One wait state per access; master follows high/low byte order.
// Notes:   Holding register is shared; interrupt code touching it corrupts
//          a main-line 16-bit access in progress.
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module timer16_register_access
  import timer16_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        ext_count_pin,
  input  wire logic        capture_input_a,
  input  wire logic        capture_input_b,
  output logic             compare_output_pin_a,
  output logic             compare_output_pin_b,
  output logic             irq
);
  timer_sig_if sig ();

  bus_state_t  state_reg;
  bus_state_t  state_next;
  logic [7:0]  ctrl_a_reg;
  logic [7:0]  ctrl_b_reg;
  logic [7:0]  ctrl_c_reg;
  logic [7:0]  power_reg;
  logic [7:0]  temp_reg;
  logic [7:0]  snap_hi_reg;
  logic [15:0] counter_reg;
  logic [15:0] counter_next;
  logic [15:0] cmpa_buf_reg;
  logic [15:0] cmpb_buf_reg;
  logic [15:0] cmpa_act_reg;
  logic [15:0] cmpb_act_reg;
  logic [15:0] capture_reg;
  logic [15:0] capture_next;
  logic [3:0]  mask_reg;
  logic [3:0]  flag_reg;
  logic [3:0]  flag_next;
  logic [3:0]  flag_set;
  logic [31:0] readdata_reg;
  logic        pin_a_reg;
  logic        pin_b_reg;
  logic [7:0]  rd_byte;

  logic        req, acc, wr_acc, rd_acc;
  logic [7:0]  wbyte;
  logic [15:0] load_word;
  logic        sel_cnt_lo, sel_cap_lo, sel_hi_any, sel_cmp_any;
  logic        wr_cnt_lo, wr_cap_lo, wr_cmpa_lo, wr_cmpb_lo;
  wgm_t        wgm;
  logic [15:0] top_val;
  logic        pwm, ocra_top, at_top, at_max, tick, retrig;
  logic        match_a, match_b, buf_load, wrap;
  logic [7:0]  cnt_hi;

  // Bus handshake: one wait cycle, access takes effect on the answer edge
  assign req         = read | write;
  assign state_next  = (state_reg == BUS_IDLE && req) ? BUS_ANSWER : BUS_IDLE;
  assign waitrequest = req & (state_reg == BUS_IDLE);
  assign acc         = req & (state_reg == BUS_ANSWER);
  assign wr_acc      = write & acc;
  assign rd_acc      = read & acc;
  assign readdata    = readdata_reg;
  assign wbyte       = writedata[7:0];

  assign sel_cnt_lo  = address == CNT_LO_OFS;
  assign sel_cap_lo  = address == CAP_LO_OFS;
  assign sel_hi_any  = address == CNT_HI_OFS || address == CMPA_HI_OFS ||
                       address == CMPB_HI_OFS || address == CAP_HI_OFS;
  assign sel_cmp_any = address == CMPA_LO_OFS || address == CMPA_HI_OFS ||
                       address == CMPB_LO_OFS || address == CMPB_HI_OFS;
  assign wr_cnt_lo   = wr_acc & sel_cnt_lo;
  assign wr_cap_lo   = wr_acc & sel_cap_lo;
  assign wr_cmpa_lo  = wr_acc & (address == CMPA_LO_OFS);
  assign wr_cmpb_lo  = wr_acc & (address == CMPB_LO_OFS);
  assign load_word   = {temp_reg, wbyte};
  assign cnt_hi      = counter_reg[15:8];

  assign wgm      = {ctrl_b_reg[WGM_HI_LSB+1:WGM_HI_LSB], ctrl_a_reg[1:0]};
  assign top_val  = top_of(wgm, cmpa_act_reg, capture_reg);
  assign pwm      = is_pwm(wgm);
  assign ocra_top = ocra_is_top(wgm);
  assign at_top   = counter_reg == top_val;
  assign at_max   = counter_reg == MAX_VAL;
  assign tick     = sig.tick;
  assign retrig   = ctrl_c_reg[RTG_EN_BIT] & sig.cap_event;
  assign wrap     = (tick & at_top) | retrig;
  assign match_a  = tick & (counter_reg == cmpa_act_reg);
  assign match_b  = tick & (counter_reg == cmpb_act_reg);
  // Outside PWM the compare values follow the buffer at once
  assign buf_load = ~pwm | wrap;

  assign sig.clk_sel   = ctrl_b_reg[CS_LSB+2:CS_LSB];
  assign sig.power_off = power_reg[POWER_BIT];
  assign sig.edge_rise = ctrl_b_reg[ICES_BIT];
  assign sig.filter_on = ctrl_b_reg[ICNC_BIT];
  assign sig.cap_sel   = ctrl_c_reg[CAP_SEL_BIT];

  // Bus write wins over clear and count
  assign counter_next = wr_cnt_lo ? load_word :
                        wrap ? BOTTOM_VAL :
                        tick ? counter_reg + 16'h0001 : counter_reg;
  assign capture_next = wr_cap_lo ? load_word :
                        sig.cap_event ? counter_reg : capture_reg;

  assign flag_set[FLAG_OVF]  = tick & ~wr_cnt_lo &
                               (pwm ? at_top : at_max);
  assign flag_set[FLAG_CMPA] = match_a;
  assign flag_set[FLAG_CMPB] = match_b;
  assign flag_set[FLAG_CAP]  = sig.cap_event;
  // Only bits the read reported are cleared; an event that lands while
  // the read is in flight stays set for the next read
  assign flag_next = ((rd_acc && address == FLAG_OFS) ?
                      (flag_reg & ~readdata_reg[3:0]) : flag_reg)
                     | flag_set;
  assign irq = |(flag_reg & mask_reg);

  assign compare_output_pin_a = pin_a_reg;
  assign compare_output_pin_b = pin_b_reg;

  always_comb
  begin
    unique case (address)
      CTRL_A_OFS:  rd_byte = ctrl_a_reg;
      CTRL_B_OFS:  rd_byte = ctrl_b_reg;
      CTRL_C_OFS:  rd_byte = ctrl_c_reg;
      POWER_OFS:   rd_byte = power_reg;
      CNT_LO_OFS:  rd_byte = counter_reg[7:0];
      CNT_HI_OFS:  rd_byte = temp_reg;
      CMPA_LO_OFS: rd_byte = cmpa_buf_reg[7:0];
      CMPA_HI_OFS: rd_byte = cmpa_buf_reg[15:8];
      CMPB_LO_OFS: rd_byte = cmpb_buf_reg[7:0];
      CMPB_HI_OFS: rd_byte = cmpb_buf_reg[15:8];
      CAP_LO_OFS:  rd_byte = capture_reg[7:0];
      CAP_HI_OFS:  rd_byte = temp_reg;
      MASK_OFS:    rd_byte = {4'h0, mask_reg};
      FLAG_OFS:    rd_byte = {4'h0, flag_reg};
      default:     rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      state_reg    <= BUS_IDLE;
      readdata_reg <= 32'h0000_0000;
      snap_hi_reg  <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      // Snapshot both bytes together so the held high matches the low
      if (read && state_reg == BUS_IDLE)
      begin
        readdata_reg <= {24'h000000, rd_byte};
        snap_hi_reg  <= sel_cap_lo ? capture_reg[15:8] : cnt_hi;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      temp_reg <= 8'h00;
    else if (wr_acc && sel_hi_any)
      temp_reg <= wbyte;
    else if (rd_acc && (sel_cnt_lo || sel_cap_lo))
      temp_reg <= snap_hi_reg;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      ctrl_a_reg <= CTRL_RESET;
      ctrl_b_reg <= CTRL_RESET;
      ctrl_c_reg <= CTRL_RESET;
      power_reg  <= POWER_RESET;
      mask_reg   <= FLAGS_NONE;
    end
    else if (wr_acc)
    begin
      if (address == CTRL_A_OFS)
        ctrl_a_reg <= {6'h00, wbyte[1:0]};
      if (address == CTRL_B_OFS)
        ctrl_b_reg <= {wbyte[7:6], 1'b0, wbyte[4:0]};
      if (address == CTRL_C_OFS)
        ctrl_c_reg <= {6'h00, wbyte[1:0]};
      if (address == POWER_OFS)
        power_reg <= {7'h00, wbyte[0]};
      if (address == MASK_OFS)
        mask_reg <= wbyte[3:0];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      counter_reg  <= BOTTOM_VAL;
      capture_reg  <= BOTTOM_VAL;
      flag_reg     <= FLAGS_NONE;
      cmpa_buf_reg <= BOTTOM_VAL;
      cmpb_buf_reg <= BOTTOM_VAL;
      cmpa_act_reg <= BOTTOM_VAL;
      cmpb_act_reg <= BOTTOM_VAL;
    end
    else
    begin
      counter_reg <= counter_next;
      capture_reg <= capture_next;
      flag_reg    <= flag_next;
      if (wr_cmpa_lo)
        cmpa_buf_reg <= load_word;
      if (wr_cmpb_lo)
        cmpb_buf_reg <= load_word;
      if (buf_load)
      begin
        cmpa_act_reg <= cmpa_buf_reg;
        cmpb_act_reg <= cmpb_buf_reg;
      end
    end
  end

  // PWM: set at BOTTOM, clear on match (pin A held low when OCRA is TOP); otherwise toggle on match
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      pin_a_reg <= 1'b0;
      pin_b_reg <= 1'b0;
    end
    else
    begin
      if (pwm && ocra_top)
        pin_a_reg <= 1'b0;
      else if (pwm)
        pin_a_reg <= match_a ? 1'b0 : (wrap ? 1'b1 : pin_a_reg);
      else if (match_a)
        pin_a_reg <= ~pin_a_reg;
      if (pwm)
        pin_b_reg <= match_b ? 1'b0 : (wrap ? 1'b1 : pin_b_reg);
      else if (match_b)
        pin_b_reg <= ~pin_b_reg;
    end
  end

  timer_tick_gen u_tick (
    .ref_clk       (ref_clk),
    .nrst          (nrst),
    .ext_count_pin (ext_count_pin),
    .sig           (sig)
  );

  timer_capture_filter u_cap (
    .ref_clk         (ref_clk),
    .nrst            (nrst),
    .capture_input_a (capture_input_a),
    .capture_input_b (capture_input_b),
    .sig             (sig)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_cnt_lo_write;
    wr_acc && sel_cnt_lo;
  endsequence
  sequence s_cnt_lo_read;
    rd_acc && sel_cnt_lo;
  endsequence
  sequence s_hi_write;
    wr_acc && sel_hi_any;
  endsequence

  a_low_write_load: assert property (s_cnt_lo_write |=>
    counter_reg == $past(load_word)) else $error("counter load wrong");
  a_high_write_hold: assert property (s_hi_write |=>
    temp_reg == $past(wbyte) && $stable(cmpa_buf_reg) &&
    $stable(cmpb_buf_reg)) else $error("high write leaked");
  a_low_read_copy: assert property (s_cnt_lo_read |=>
    temp_reg == $past(cnt_hi, 2)) else $error("high byte not held");
  a_cmp_read_keep: assert property (rd_acc && sel_cmp_any |=>
    $stable(temp_reg)) else $error("compare read touched holder");
  a_stop_frozen: assert property (sig.clk_sel == CS_OFF &&
    !wr_cnt_lo && !retrig |=> $stable(counter_reg))
    else $error("counter moved without clock");
  a_top_wrap: assert property (tick && at_top && !wr_cnt_lo |=>
    counter_reg == BOTTOM_VAL) else $error("no wrap at top");
  a_max_overflow: assert property (tick && at_max && !pwm &&
    !wr_cnt_lo |=> flag_reg[FLAG_OVF]) else $error("no overflow at max");
  a_cmp_match: assert property (match_a |=>
    flag_reg[FLAG_CMPA]) else $error("compare A flag missed");
  a_capture_store: assert property (sig.cap_event && !wr_cap_lo |=>
    capture_reg == $past(counter_reg)) else $error("capture missed");
  a_retrig_clear: assert property (retrig && !wr_cnt_lo |=>
    counter_reg == BOTTOM_VAL) else $error("retrigger ignored");
  a_irq_mask: assert property (wr_acc && address == MASK_OFS &&
    wbyte[3:0] == FLAGS_NONE |=> !irq) else $error("masked irq high");
  a_ocra_pin_low: assert property (pwm && ocra_top ##1 pwm && ocra_top
    |-> !compare_output_pin_a) else $error("top channel drove pin");
  a_ctrl_single: assert property (read && waitrequest &&
    address == CTRL_B_OFS ##1 rd_acc |-> readdata[7:0] == ctrl_b_reg)
    else $error("control read wrong");

endmodule : timer16_register_access

// File: timer16_pkg.sv
// Purpose: Constants, register map and helpers for the 16-bit timer block.
// Assumes: Avalon-MM slave with 32-bit words, timer data in the low byte.
// Notes:   All counting is upward; waveform modes are reduced to up-count.
package timer16_pkg;

  localparam logic [5:0] CTRL_A_OFS  = 6'h00;
  localparam logic [5:0] CTRL_B_OFS  = 6'h04;
  localparam logic [5:0] CTRL_C_OFS  = 6'h08;
  localparam logic [5:0] POWER_OFS   = 6'h0C;
  localparam logic [5:0] CNT_LO_OFS  = 6'h10;
  localparam logic [5:0] CNT_HI_OFS  = 6'h14;
  localparam logic [5:0] CMPA_LO_OFS = 6'h18;
  localparam logic [5:0] CMPA_HI_OFS = 6'h1C;
  localparam logic [5:0] CMPB_LO_OFS = 6'h20;
  localparam logic [5:0] CMPB_HI_OFS = 6'h24;
  localparam logic [5:0] CAP_LO_OFS  = 6'h28;
  localparam logic [5:0] CAP_HI_OFS  = 6'h2C;
  localparam logic [5:0] MASK_OFS    = 6'h30;
  localparam logic [5:0] FLAG_OFS    = 6'h34;

  localparam int FLAG_OVF  = 0;
  localparam int FLAG_CMPA = 1;
  localparam int FLAG_CMPB = 2;
  localparam int FLAG_CAP  = 3;

  localparam int CS_LSB      = 0;
  localparam int WGM_HI_LSB  = 3;
  localparam int ICES_BIT    = 6;
  localparam int ICNC_BIT    = 7;
  localparam int RTG_EN_BIT  = 0;
  localparam int CAP_SEL_BIT = 1;
  localparam int POWER_BIT   = 0;

  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] POWER_RESET = 8'h01;
  localparam logic [3:0] FLAGS_NONE  = 4'h0;

  localparam logic [15:0] BOTTOM_VAL = 16'h0000;
  localparam logic [15:0] MAX_VAL    = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT   = 16'h00FF;
  localparam logic [15:0] TOP_9BIT   = 16'h01FF;
  localparam logic [15:0] TOP_10BIT  = 16'h03FF;

  localparam logic [2:0] CS_OFF     = 3'h0;
  localparam logic [2:0] CS_DIV1    = 3'h1;
  localparam logic [2:0] CS_DIV8    = 3'h2;
  localparam logic [2:0] CS_DIV64   = 3'h3;
  localparam logic [2:0] CS_DIV256  = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  localparam logic [9:0] PRE_MASK_8    = 10'h007;
  localparam logic [9:0] PRE_MASK_64   = 10'h03F;
  localparam logic [9:0] PRE_MASK_256  = 10'h0FF;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;

  localparam logic [3:0] FILTER_ALL_HIGH = 4'hF;
  localparam logic [3:0] FILTER_ALL_LOW  = 4'h0;

  typedef logic [3:0] wgm_t;
  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;

  function automatic logic [15:0] top_of(input wgm_t m,
                                         input logic [15:0] cmp_a,
                                         input logic [15:0] cap);
    unique case (m)
      4'h1, 4'h5:               top_of = TOP_8BIT;
      4'h2, 4'h6:               top_of = TOP_9BIT;
      4'h3, 4'h7:               top_of = TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF:   top_of = cmp_a;
      4'h8, 4'hA, 4'hC, 4'hE:   top_of = cap;
      default:                  top_of = MAX_VAL;
    endcase
  endfunction : top_of

  function automatic logic is_pwm(input wgm_t m);
    is_pwm = !(m == 4'h0 || m == 4'h4 || m == 4'hC || m == 4'hD);
  endfunction : is_pwm

  function automatic logic ocra_is_top(input wgm_t m);
    ocra_is_top = (m == 4'h4 || m == 4'h9 || m == 4'hB || m == 4'hF);
  endfunction : ocra_is_top

endpackage : timer16_pkg

// File: timer_sig_if.sv
// Purpose: Carries tick and capture signals between the timer modules.
// Assumes: Single clock domain, all members sampled on ref_clk.
// Notes:   Core drives configuration, leaves drive events.
`timescale 1ns/1ps
interface timer_sig_if;
  logic       tick;
  logic       cap_event;
  logic       power_off;
  logic [2:0] clk_sel;
  logic       edge_rise;
  logic       filter_on;
  logic       cap_sel;
  modport gen  (input clk_sel, power_off, output tick);
  modport cap  (input edge_rise, filter_on, cap_sel, output cap_event);
  modport core (output clk_sel, power_off, edge_rise, filter_on, cap_sel,
                input tick, cap_event);
endinterface : timer_sig_if

// File: timer_tick_gen.sv
// Purpose: Prescaler and external pin edge select giving the timer tick.
// Assumes: ext_count_pin is synchronous to ref_clk.
// Notes:   Prescaler runs free so ticks stay evenly spaced across writes.
`timescale 1ns/1ps
module timer_tick_gen
  import timer16_pkg::*;
(
  input  wire logic   ref_clk,
  input  wire logic   nrst,
  input  wire logic   ext_count_pin,
  timer_sig_if.gen    sig
);
  logic [9:0] pre_reg;
  logic       pin_prev_reg;
  logic       pin_rise;
  logic       pin_fall;
  logic       raw_tick;

  assign pin_rise = ext_count_pin & ~pin_prev_reg;
  assign pin_fall = ~ext_count_pin & pin_prev_reg;

  always_comb
  begin
    unique case (sig.clk_sel)
      CS_OFF:      raw_tick = 1'b0;
      CS_DIV1:     raw_tick = 1'b1;
      CS_DIV8:     raw_tick = (pre_reg & PRE_MASK_8) == PRE_MASK_8;
      CS_DIV64:    raw_tick = (pre_reg & PRE_MASK_64) == PRE_MASK_64;
      CS_DIV256:   raw_tick = (pre_reg & PRE_MASK_256) == PRE_MASK_256;
      CS_DIV1024:  raw_tick = pre_reg == PRE_MASK_1024;
      CS_EXT_FALL: raw_tick = pin_fall;
      CS_EXT_RISE: raw_tick = pin_rise;
    endcase
  end

  // Power-off stops the tick; capture and retrigger still act
  assign sig.tick = raw_tick & ~sig.power_off;

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      pre_reg      <= 10'h000;
      pin_prev_reg <= 1'b0;
    end
    else
    begin
      pre_reg      <= pre_reg + 10'h001;
      pin_prev_reg <= ext_count_pin;
    end
  end
endmodule : timer_tick_gen

// File: timer_capture_filter.sv
// Purpose: Capture input select, noise filter and edge detector.
// Assumes: Capture inputs are synchronous to ref_clk.
// Notes:   Filter adds four cycles of delay; unfiltered path adds one.
`timescale 1ns/1ps
module timer_capture_filter
  import timer16_pkg::*;
(
  input  wire logic   ref_clk,
  input  wire logic   nrst,
  input  wire logic   capture_input_a,
  input  wire logic   capture_input_b,
  timer_sig_if.cap    sig
);
  logic [3:0] hist_reg;
  logic       level_reg;
  logic       level_next;
  logic       prev_reg;
  logic       sample;

  assign sample = sig.cap_sel ? capture_input_b : capture_input_a;
  // Filtered level moves only after four equal samples
  assign level_next = !sig.filter_on ? sample :
                      (hist_reg == FILTER_ALL_HIGH) ? 1'b1 :
                      (hist_reg == FILTER_ALL_LOW) ? 1'b0 : level_reg;
  assign sig.cap_event = sig.edge_rise ? (level_reg & ~prev_reg)
                                       : (~level_reg & prev_reg);

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      hist_reg  <= 4'h0;
      level_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end
    else
    begin
      hist_reg  <= {hist_reg[2:0], sample};
      level_reg <= level_next;
      prev_reg  <= level_reg;
    end
  end
endmodule : timer_capture_filter

// File: cpu_bus_model.sv
// Purpose: Processor-side byte master for the timer register port.
// Assumes: Avalon-MM, one request at a time, timer data in bits 7:0.
// Notes:   A request stays up until waitrequest is seen low at an edge.
`timescale 1ns/1ps
module cpu_bus_model
  import timer16_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest,
  output logic      [5:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata
);
  initial
  begin
    address   = 6'h00;
    read      = 1'b0;
    write     = 1'b0;
    writedata = 32'h0000_0000;
  end

  // Enter just after a rising edge; returns one edge after release so
  // that the next request never lands in the same time step
  task automatic xfer(input logic [5:0] a, input logic wr,
                      input logic [7:0] d, output logic [7:0] q);
    address   <= a;
    write     <= wr;
    read      <= !wr;
    writedata <= {24'h000000, d};
    do
      @(posedge ref_clk);
    while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read      <= 1'b0;
    write     <= 1'b0;
    writedata <= ~writedata;
    @(posedge ref_clk);
  endtask : xfer

  task automatic wr16(input logic [5:0] lo, input logic [15:0] d);
    logic [7:0] q;
    xfer(lo + 6'h04, 1'b1, d[15:8], q);
    xfer(lo, 1'b1, d[7:0], q);
  endtask : wr16

  task automatic rd16(input logic [5:0] lo, output logic [15:0] d);
    xfer(lo, 1'b0, 8'h00, d[7:0]);
    xfer(lo + 6'h04, 1'b0, 8'h00, d[15:8]);
  endtask : rd16
endmodule : cpu_bus_model

// File: timer16_register_access_test.sv
// Purpose: Self-checking bench for the 16-bit timer register port.
// Assumes: Timer stopped unless a test selects a clock source.
// Notes:   Ext pin pulses stand in for ticks, so counts are exact.
`timescale 1ns/1ps
module timer16_register_access_test
  import timer16_pkg::*;
();
  logic        ref_clk         = 1'b0;
  logic        nrst            = 1'b0;
  logic        ext_count_pin   = 1'b0;
  logic        capture_input_a = 1'b0;
  logic        capture_input_b = 1'b0;
  logic [5:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        pin_a;
  logic        pin_b;
  logic        irq;
  int          num_errors = 0;
  int          cmp_count  = 0;
  logic [3:0]  modes [7]  = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h9, 4'hC, 4'h8};

  always #25 ref_clk = ~ref_clk;

  timer16_register_access uut (
    .ref_clk(ref_clk), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .ext_count_pin(ext_count_pin),
    .capture_input_a(capture_input_a), .capture_input_b(capture_input_b),
    .compare_output_pin_a(pin_a), .compare_output_pin_b(pin_b), .irq(irq));

  cpu_bus_model cpu (
    .ref_clk(ref_clk), .readdata(readdata), .waitrequest(waitrequest),
    .address(address), .read(read), .write(write), .writedata(writedata));

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check16

  task automatic check1(input logic got, input logic exp);
    check16({15'h0000, got}, {15'h0000, exp});
  endtask : check1

  task automatic wr8(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    cpu.xfer(a, 1'b1, d, q);
  endtask : wr8

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] q;
    cpu.xfer(a, 1'b0, 8'h00, q);
    check16({8'h00, q}, {8'h00, exp});
  endtask : rd_chk

  task automatic rd16_chk(input logic [5:0] a, input logic [15:0] exp);
    logic [15:0] q;
    cpu.rd16(a, q);
    check16(q, exp);
  endtask : rd16_chk

  // Two spare edges let the tick's register updates settle before checks
  task automatic ticks(input int n);
    repeat (n)
    begin
      ext_count_pin <= 1'b1;
      @(posedge ref_clk);
      ext_count_pin <= 1'b0;
      @(posedge ref_clk);
    end
    repeat (2) @(posedge ref_clk);
  endtask : ticks

  function automatic logic [15:0] top_expect(input logic [3:0] m,
                                             input logic [15:0] t);
    case (m)
      4'h1:    top_expect = 16'h00FF;
      4'h2:    top_expect = 16'h01FF;
      4'h3:    top_expect = 16'h03FF;
      default: top_expect = t;
    endcase
  endfunction : top_expect

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    report_and_stop();
  end

  initial
  begin
    logic [15:0] y;
    logic [15:0] t;
    logic [7:0]  q;
    int          n;
    void'($urandom(14));
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    rd_chk(POWER_OFS, POWER_RESET);
    rd_chk(CTRL_B_OFS, CTRL_RESET);
    rd_chk(FLAG_OFS, 8'h00);
    rd_chk(6'h3C, 8'h00);
    check1(irq, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      y = 16'($urandom);
      wr8(CTRL_A_OFS, {6'h00, y[1:0]});
      wr8(CTRL_C_OFS, {6'h00, y[3:2]});
      wr8(MASK_OFS, {4'h0, y[7:4]});
      rd_chk(CTRL_A_OFS, {6'h00, y[1:0]});
      rd_chk(CTRL_C_OFS, {6'h00, y[3:2]});
      rd_chk(MASK_OFS, {4'h0, y[7:4]});
    end
    wr8(CTRL_A_OFS, 8'h00);
    wr8(CTRL_C_OFS, 8'h00);
    // Holding register, counter still frozen by the power-off bit
    y = 16'($urandom);
    t = 16'($urandom);
    cpu.wr16(CMPA_LO_OFS, t);
    cpu.wr16(CNT_LO_OFS, y);
    rd16_chk(CNT_LO_OFS, y);
    wr8(CMPA_HI_OFS, ~t[15:8]);
    cpu.xfer(CNT_LO_OFS, 1'b0, 8'h00, q);
    rd_chk(CMPA_LO_OFS, t[7:0]);
    rd_chk(CMPA_HI_OFS, t[15:8]);
    rd_chk(CNT_HI_OFS, y[15:8]);
    wr8(CNT_HI_OFS, t[7:0]);
    wr8(CMPB_LO_OFS, y[7:0]);
    rd16_chk(CMPB_LO_OFS, {t[7:0], y[7:0]});
    // Counting from the external pin, then with no source
    wr8(POWER_OFS, 8'h00);
    wr8(CTRL_B_OFS, {5'h00, CS_EXT_RISE});
    cpu.wr16(CNT_LO_OFS, y);
    n = 1 + $urandom % 9;
    ticks(n);
    rd16_chk(CNT_LO_OFS, y + 16'(n));
    wr8(CTRL_B_OFS, {5'h00, CS_OFF});
    ticks(3);
    rd16_chk(CNT_LO_OFS, y + 16'(n));
    wr8(CTRL_B_OFS, {5'h00, CS_EXT_FALL});
    ticks(2);
    rd16_chk(CNT_LO_OFS, y + 16'(n) + 16'h0002);
    // Overflow at MAX, interrupt masking and clear on read
    wr8(CTRL_B_OFS, {5'h00, CS_EXT_RISE});
    cpu.xfer(FLAG_OFS, 1'b0, 8'h00, q);
    wr8(MASK_OFS, 8'h01);
    cpu.wr16(CNT_LO_OFS, MAX_VAL);
    ticks(1);
    check1(irq, 1'b1);
    wr8(MASK_OFS, 8'h00);
    check1(irq, 1'b0);
    rd16_chk(CNT_LO_OFS, BOTTOM_VAL);
    rd_chk(FLAG_OFS, 8'h01);
    wr8(MASK_OFS, 8'h0F);
    check1(irq, 1'b0);
    // Both compare channels match on consecutive ticks
    y = 16'($urandom) & 16'h7FFF;
    cpu.wr16(CMPA_LO_OFS, y + 16'h0001);
    cpu.wr16(CMPB_LO_OFS, y + 16'h0002);
    cpu.wr16(CNT_LO_OFS, y);
    cpu.xfer(FLAG_OFS, 1'b0, 8'h00, q);
    q = {6'h00, pin_b, pin_a};
    ticks(3);
    check1(irq, 1'b1);
    rd_chk(FLAG_OFS, 8'h06);
    check1(pin_a, ~q[0]);
    check1(pin_b, ~q[1]);
    // Wrap at each fixed, compare A and capture TOP
    t = 16'($urandom) | 16'h0100;
    cpu.wr16(CMPA_LO_OFS, t);
    cpu.wr16(CAP_LO_OFS, t);
    foreach (modes[i])
    begin
      wr8(CTRL_A_OFS, {6'h00, modes[i][1:0]});
      wr8(CTRL_B_OFS, {3'h0, modes[i][3:2], CS_EXT_RISE});
      cpu.wr16(CNT_LO_OFS, top_expect(modes[i], t));
      ticks(1);
      rd16_chk(CNT_LO_OFS, BOTTOM_VAL);
      if (modes[i] == 4'h9)
        check1(pin_a, 1'b0);
    end
    // Capture on each input; input A also retriggers the counter
    wr8(CTRL_A_OFS, 8'h00);
    wr8(CTRL_B_OFS, 8'h40);
    for (int i = 0; i < 2; i++)
    begin
      y = 16'($urandom) | 16'h0001;
      wr8(CTRL_C_OFS, (i == 0) ? 8'h01 : 8'h02);
      cpu.wr16(CNT_LO_OFS, y);
      cpu.xfer(FLAG_OFS, 1'b0, 8'h00, q);
      capture_input_a <= (i == 0);
      capture_input_b <= (i == 1);
      repeat (8) @(posedge ref_clk);
      capture_input_a <= 1'b0;
      capture_input_b <= 1'b0;
      repeat (8) @(posedge ref_clk);
      rd16_chk(CAP_LO_OFS, y);
      rd16_chk(CNT_LO_OFS, (i == 0) ? BOTTOM_VAL : y);
      rd_chk(FLAG_OFS, 8'h08);
    end
    // Filter drops a short glitch, then a falling edge is captured
    wr8(CTRL_B_OFS, 8'h80);
    y = 16'($urandom);
    cpu.wr16(CNT_LO_OFS, y);
    cpu.xfer(FLAG_OFS, 1'b0, 8'h00, q);
    capture_input_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    capture_input_b <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rd_chk(FLAG_OFS, 8'h00);
    capture_input_b <= 1'b1;
    repeat (8) @(posedge ref_clk);
    capture_input_b <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rd16_chk(CAP_LO_OFS, y);
    rd_chk(FLAG_OFS, 8'h08);
    // Prescaler: 72 cycles between the two snapshots hold nine ticks
    wr8(CTRL_B_OFS, {5'h00, CS_DIV8});
    cpu.rd16(CNT_LO_OFS, y);
    repeat (66) @(posedge ref_clk);
    cpu.rd16(CNT_LO_OFS, t);
    check16(t - y, 16'h0009);
    report_and_stop();
  end
endmodule : timer16_register_access_test
